// File: core/epoch_ram_params.svh
// constants for the epoch counter, scratch bytes and key gate
`ifndef EPOCH_RAM_PARAMS_SVH
`define EPOCH_RAM_PARAMS_SVH
`define ADDR_EPOCH0 8'h1b
`define ADDR_EPOCH1 8'h1c
`define ADDR_EPOCH2 8'h1d
`define ADDR_EPOCH3 8'h1e
`define ADDR_SCRATCH1 8'h1f
`define ADDR_SCRATCH2 8'h20
`define ADDR_KEY0 8'h21
`define ADDR_KEY1 8'h22
`define ADDR_KEY2 8'h23
`define ADDR_KEY3 8'h24
`define SCRATCH_RESET 8'h00
`define EPOCH_RESET 32'h00000000
`define READ_RESET 8'h00
`define KEY_RESET 8'h00
`define KEY_ENABLE_VALUE 8'hff
`define REFRESH_MS 66
`define CLOCK_HZ 10000000
`define REFRESH_CYCLES ((`CLOCK_HZ / 1000) * `REFRESH_MS)
`endif

// File: core/epoch_ram_pkg.sv
// types for the epoch counter and key gate block
package epoch_ram_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {st_refresh, st_run} boot_state_t;
endpackage : epoch_ram_pkg

// File: core/key_gate_if.sv
// carrier between register file and key gate
`timescale 1ns/1ps
`default_nettype none
interface key_gate_if;
  logic [31:0] entered;
  logic [7:0] nv_enable;
  logic [31:0] nv_key;
  logic allow;
  modport regs (output entered, output nv_enable, output nv_key, input allow);
  modport gate (input entered, input nv_enable, input nv_key, output allow);
endinterface : key_gate_if
`default_nettype wire

// File: core/key_gate.sv
// key comparison deciding whether a gated write may land
`timescale 1ns/1ps
`default_nettype none
`include "epoch_ram_params.svh"
module key_gate (
  key_gate_if.gate kg
);
  import epoch_ram_pkg::*;
  always_comb begin
    if (kg.nv_enable == `KEY_ENABLE_VALUE) begin
      kg.allow = (kg.entered == kg.nv_key);
    end else begin
      kg.allow = 1'b1;
    end
  end
endmodule : key_gate
`default_nettype wire

// File: core/epoch_ram_write_protect_regs.sv
// epoch counter bytes, scratch bytes and key entry registers
`timescale 1ns/1ps
`default_nettype none
`include "epoch_ram_params.svh"
module epoch_ram_write_protect_regs (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // tuned 1 hz tick, one-cycle pulse, same domain
  input wire logic tick_1hz,
  // register access from the serial front end
  input wire logic wr_en,
  input wire logic rd_en,
  input wire epoch_ram_pkg::byte_t addr,
  input wire epoch_ram_pkg::byte_t wr_data,
  input wire logic counter_write_busy,
  output epoch_ram_pkg::byte_t rd_data,
  // nonvolatile mirror of enable and stored key
  input wire epoch_ram_pkg::byte_t nv_key_enable,
  input wire epoch_ram_pkg::byte_t nv_key_byte0,
  input wire epoch_ram_pkg::byte_t nv_key_byte1,
  input wire epoch_ram_pkg::byte_t nv_key_byte2,
  input wire epoch_ram_pkg::byte_t nv_key_byte3,
  // status
  output logic write_allowed,
  output logic refresh_done,
  output epoch_ram_pkg::word_t epoch_count
);
  import epoch_ram_pkg::*;

  localparam logic [19:0] refresh_last = 20'(`REFRESH_CYCLES - 1);

  key_gate_if kg ();
  key_gate key_gate_inst (.kg(kg));

  // state, one group per always_ff
  boot_state_t boot_q, boot_d;
  logic [19:0] boot_cnt_q, boot_cnt_d;
  logic done_q, done_d;
  word_t epoch_q, epoch_d;
  byte_t scratch1_q, scratch1_d, scratch2_q, scratch2_d;
  byte_t key0_q, key0_d, key1_q, key1_d, key2_q, key2_d, key3_q, key3_d;
  byte_t rd_q, rd_d;
  logic allow_q, allow_d;
  logic gated_ok;
  logic counter_hit;
  logic tick_ok;

  function automatic logic is_counter_addr(input byte_t a);
    is_counter_addr = (a >= `ADDR_EPOCH0) && (a <= `ADDR_EPOCH3);
  endfunction : is_counter_addr

  // write qualifiers shared by the counter and scratch groups
  assign gated_ok = wr_en && kg.allow;
  assign counter_hit = wr_en && is_counter_addr(addr);
  // a tick meeting a counter write is lost, not deferred
  assign tick_ok = tick_1hz && !counter_write_busy && !counter_hit;

  // key gate wiring
  assign kg.entered = {key3_q, key2_q, key1_q, key0_q};
  assign kg.nv_enable = nv_key_enable;
  assign kg.nv_key = {nv_key_byte3, nv_key_byte2, nv_key_byte1, nv_key_byte0};

  // power-up refresh: key bytes held at zero until it ends
  always_comb begin
    boot_d = boot_q;
    boot_cnt_d = boot_cnt_q;
    case (boot_q)
      st_refresh: begin
        if (boot_cnt_q == refresh_last) begin
          boot_d = st_run;
        end else begin
          boot_cnt_d = boot_cnt_q + 20'h00001;
        end
      end
      default: boot_d = st_run;
    endcase
    done_d = (boot_d == st_run);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      boot_q <= st_refresh;
      boot_cnt_q <= 20'h00000;
      done_q <= 1'b0;
    end else begin
      boot_q <= boot_d;
      boot_cnt_q <= boot_cnt_d;
      done_q <= done_d;
    end
  end

  // counter: writes go through the gate; refused ones change no byte but still drop a tick in their cycle
  always_comb begin
    epoch_d = epoch_q;
    if (gated_ok && addr == `ADDR_EPOCH0) begin
      epoch_d[7:0] = wr_data;
    end else if (gated_ok && addr == `ADDR_EPOCH1) begin
      epoch_d[15:8] = wr_data;
    end else if (gated_ok && addr == `ADDR_EPOCH2) begin
      epoch_d[23:16] = wr_data;
    end else if (gated_ok && addr == `ADDR_EPOCH3) begin
      epoch_d[31:24] = wr_data;
    end else if (tick_ok) begin
      epoch_d = epoch_q + 32'h00000001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      epoch_q <= `EPOCH_RESET;
    end else begin
      epoch_q <= epoch_d;
    end
  end

  // scratch bytes: plain storage, a scratch write never costs a tick
  always_comb begin
    scratch1_d = scratch1_q;
    scratch2_d = scratch2_q;
    if (gated_ok && addr == `ADDR_SCRATCH1) begin
      scratch1_d = wr_data;
    end else if (gated_ok && addr == `ADDR_SCRATCH2) begin
      scratch2_d = wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scratch1_q <= `SCRATCH_RESET;
      scratch2_q <= `SCRATCH_RESET;
    end else begin
      scratch1_q <= scratch1_d;
      scratch2_q <= scratch2_d;
    end
  end

  // key entry; writes during the refresh are lost
  always_comb begin
    key0_d = key0_q;
    key1_d = key1_q;
    key2_d = key2_q;
    key3_d = key3_q;
    // key bytes themselves are never gated, else a locked part could not be unlocked
    if (boot_q == st_refresh) begin
      key0_d = `KEY_RESET;
      key1_d = `KEY_RESET;
      key2_d = `KEY_RESET;
      key3_d = `KEY_RESET;
    end else if (wr_en && addr == `ADDR_KEY0) begin
      key0_d = wr_data;
    end else if (wr_en && addr == `ADDR_KEY1) begin
      key1_d = wr_data;
    end else if (wr_en && addr == `ADDR_KEY2) begin
      key2_d = wr_data;
    end else if (wr_en && addr == `ADDR_KEY3) begin
      key3_d = wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      key0_q <= `KEY_RESET;
      key1_q <= `KEY_RESET;
      key2_q <= `KEY_RESET;
      key3_q <= `KEY_RESET;
    end else begin
      key0_q <= key0_d;
      key1_q <= key1_d;
      key2_q <= key2_d;
      key3_q <= key3_d;
    end
  end

  // read mux, registered; unmapped and key addresses read zero
  always_comb begin
    rd_d = rd_q;
    if (rd_en) begin
      if (addr == `ADDR_EPOCH0) begin
        rd_d = epoch_q[7:0];
      end else if (addr == `ADDR_EPOCH1) begin
        rd_d = epoch_q[15:8];
      end else if (addr == `ADDR_EPOCH2) begin
        rd_d = epoch_q[23:16];
      end else if (addr == `ADDR_EPOCH3) begin
        rd_d = epoch_q[31:24];
      end else if (addr == `ADDR_SCRATCH1) begin
        rd_d = scratch1_q;
      end else if (addr == `ADDR_SCRATCH2) begin
        rd_d = scratch2_q;
      end else begin
        rd_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_q <= `READ_RESET;
    end else begin
      rd_q <= rd_d;
    end
  end

  // gate decision registered, one cycle behind key and enable inputs
  always_comb begin
    allow_d = kg.allow;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      allow_q <= 1'b0;
    end else begin
      allow_q <= allow_d;
    end
  end

  // every output straight from a flip-flop
  assign rd_data = rd_q;
  assign write_allowed = allow_q;
  assign refresh_done = done_q;
  assign epoch_count = epoch_q;
endmodule : epoch_ram_write_protect_regs
`default_nettype wire

// File: test/host_model.sv
// host side register access model
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock and read data
  input wire logic clock,
  input wire logic [7:0] rd_data,
  // access strobes
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wr_data
);
  initial {wr_en, rd_en, addr, wr_data} = 18'h0;
  // idle edge before each access, so a strobe is never set at its own release edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    // registered data stands until the next read strobe
    @(posedge clock);
    d = rd_data;
  endtask : rd
endmodule : host_model
`default_nettype wire

// File: test/epoch_regs_sva.sv
// port assertions for the epoch register slice
`timescale 1ns/1ps
`default_nettype none
module epoch_regs_sva (
  // watched ports
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tick_1hz,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic counter_write_busy,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] nv_key_enable,
  input wire logic write_allowed,
  input wire logic [31:0] epoch_count
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_b2; rd_en && addr == 8'h1d |=> rd_data == $past(epoch_count[23:16]); endproperty
  a_b2: assert property (p_b2) else $error("byte2 read");
  property p_b3; rd_en && addr == 8'h1e |=> rd_data == $past(epoch_count[31:24]); endproperty
  a_b3: assert property (p_b3) else $error("byte3 read");
  property p_key; rd_en && addr inside {[8'h21:8'h24]} |=> rd_data == 8'h00; endproperty
  a_key: assert property (p_key) else $error("key read");
  property p_hold; !rd_en |=> $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_inc; tick_1hz && !counter_write_busy && !(wr_en && addr inside {[8'h1b:8'h1e]})
    |=> epoch_count == $past(epoch_count) + 32'h1; endproperty
  a_inc: assert property (p_inc) else $error("count step");
  property p_busy; counter_write_busy && !wr_en |=> $stable(epoch_count); endproperty
  a_busy: assert property (p_busy) else $error("count moved");
  property p_free; nv_key_enable != 8'hff |=> write_allowed; endproperty
  a_free: assert property (p_free) else $error("gate shut");
  // a tick at the write edge must be dropped, lower bytes untouched
  property p_wr3; wr_en && addr == 8'h1e && nv_key_enable != 8'hff
    |=> epoch_count == {$past(wr_data), $past(epoch_count[23:0])}; endproperty
  a_wr3: assert property (p_wr3) else $error("byte3 write");
  c_tick: cover property (tick_1hz && !counter_write_busy);
  c_wr3: cover property (wr_en && addr == 8'h1e);
  c_shut: cover property (!write_allowed && wr_en);
endmodule : epoch_regs_sva
bind epoch_ram_write_protect_regs epoch_regs_sva epoch_regs_sva_inst (.clock, .sys_rst, .tick_1hz, .wr_en, .rd_en,
  .addr, .wr_data, .counter_write_busy, .rd_data, .nv_key_enable, .write_allowed, .epoch_count);
`default_nettype wire

// File: test/epoch_ram_write_protect_regs_bench.sv
// self-checking bench for the epoch register slice
`timescale 1ns/1ps
`default_nettype none
module epoch_ram_write_protect_regs_bench;
  logic clock = 1'b0, sys_rst = 1'b1, tick_1hz = 1'b0, counter_write_busy = 1'b0, wr_en, rd_en, write_allowed;
  logic [7:0] addr, wr_data, rd_data, rv, nv_key_enable = 8'h00, nv_key_byte0 = 8'h00;
  logic [7:0] nv_key_byte1 = 8'h00, nv_key_byte2 = 8'h00, nv_key_byte3 = 8'h00;
  logic [31:0] epoch_count, seed = 32'h00001d4f;
  logic refresh_done;
  int mismatches = 0, comparisons = 0;
  always #50 clock = ~clock;
  epoch_ram_write_protect_regs epoch_ram_write_protect_regs_inst (.clock, .sys_rst, .tick_1hz, .wr_en, .rd_en, .addr,
    .wr_data, .counter_write_busy, .rd_data, .nv_key_enable, .nv_key_byte0, .nv_key_byte1, .nv_key_byte2,
    .nv_key_byte3, .write_allowed, .refresh_done, .epoch_count);
  host_model host_model_inst (.clock, .rd_data, .wr_en, .rd_en, .addr, .wr_data);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input logic [31:0] exp);
    @(posedge clock);
    tick_1hz <= 1'b1;
    @(posedge clock);
    tick_1hz <= 1'b0;
    @(posedge clock);
    chk(epoch_count, exp, "count");
  endtask : tick
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    host_model_inst.rd(8'h20, rv);
    chk(rv, 8'h00, "scratch reset");
    chk(refresh_done, 1'b0, "refresh");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      host_model_inst.wr(8'h1f + i[0], seed[7:0]);
      host_model_inst.rd(8'h1f + i[0], rv);
      chk(rv, seed[7:0], "scratch");
    end
    for (int i = 0; i < 4; i++) host_model_inst.wr(8'h1b + i[7:0], {7'h7f, i != 0});
    tick(32'hffffffff);
    tick(32'h0);
    host_model_inst.wr(8'h1d, seed[15:8]);
    host_model_inst.wr(8'h1e, seed[23:16]);
    host_model_inst.rd(8'h1d, rv);
    chk(rv, seed[15:8], "byte2");
    host_model_inst.rd(8'h1e, rv);
    chk(rv, seed[23:16], "byte3");
    counter_write_busy <= 1'b1;
    tick({seed[23:8], 16'h0});
    counter_write_busy <= 1'b0;
    // a scratch write in the tick cycle must not cost the tick
    fork
      host_model_inst.wr(8'h20, 8'h5a);
      tick({seed[23:8], 16'h0001});
    join
    for (int i = 0; i < 4; i++) begin
      host_model_inst.wr(8'h21 + i[7:0], seed[7:0]);
      host_model_inst.rd(8'h21 + i[7:0], rv);
      chk(rv, 8'h00, "key read");
    end
    // key entry is held at zero through the refresh, so a nonzero stored key must refuse
    host_model_inst.wr(8'h1f, 8'ha5);
    nv_key_enable <= 8'hff;
    nv_key_byte0 <= seed[31:24] | 8'h01;
    host_model_inst.wr(8'h1f, 8'h3c);
    host_model_inst.rd(8'h1f, rv);
    chk(rv, 8'ha5, "refused write");
    chk(write_allowed, 1'b0, "gate shut");
    nv_key_byte0 <= 8'h00;
    host_model_inst.wr(8'h1f, 8'h3c);
    host_model_inst.rd(8'h1f, rv);
    chk(rv, 8'h3c, "matched write");
    report_and_stop();
  end
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
endmodule : epoch_ram_write_protect_regs_bench
`default_nettype wire
